// >>> hw/oad_defines.svh
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
// Opcode values of the specially decoded instructions, the first five with legality checks
`define OAD_OPC_HALT 8'h00
`define OAD_OPC_LOAD_CTX 8'h06
`define OAD_OPC_SAVE_CTX 8'h07
`define OAD_OPC_WR_PREG 8'hda
`define OAD_OPC_RD_PREG 8'hdb
`define OAD_OPC_POLY_F 8'h55
`define OAD_OPC_CALL_STK 8'hfb
`define OAD_OPC_PROBE_RD 8'h0c
`define OAD_OPC_PROBE_WR 8'h0d
`define OAD_OPC_BIT_SET_SET 8'he2
`define OAD_OPC_BIT_CLR_CLR 8'he5
`define OAD_OPC_LOCK_BIT_SET 8'he6
`define OAD_OPC_LOCK_BIT_CLR 8'he7
// Access type letters
`define OAD_ACC_A 3'h0
`define OAD_ACC_B 3'h1
`define OAD_ACC_M 3'h2
`define OAD_ACC_R 3'h3
`define OAD_ACC_V 3'h4
`define OAD_ACC_W 3'h5
// Implied register block written by single polynomial
`define OAD_POLY_REG_MASK 16'h000f
// Access mode and branch condition encodings
`define OAD_MODE_KERNEL 2'h0
`define OAD_COND_CARRY_SET 4'h6
`define OAD_COND_UNSIGNED_BELOW 4'h7
`define OAD_COND_CARRY_ZERO 4'h8
`define OAD_COND_UNSIGNED_NOT_BELOW 4'h9
`endif

// >>> hw/oad_pkg.sv
package oad_pkg;
    typedef enum logic [3:0] {
        DT_BYTE, DT_WORD, DT_LONG, DT_QUAD, DT_OCTA,
        DT_FLT_F, DT_FLT_D, DT_FLT_G, DT_FLT_H, DT_FIELD, DT_FIRST, DT_SECOND
    } oad_dtype_t;

    typedef struct packed {
        logic [2:0] acc;
        oad_dtype_t dtype;
        logic reg_mode;
        logic [3:0] reg_num;
    } oad_spec_t;

    typedef struct packed {
        logic fetch;
        logic store;
        logic addr_out;
        logic branch;
        logic reg_pair;
        logic [3:0] reg_hi;
        logic [4:0] size_bytes;
        oad_dtype_t eff_dtype;
    } oad_opdec_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [1:0] cur_mode;
        logic on_int_stack;
        logic [3:0] cond;
        logic addend_neg;
        oad_dtype_t dt_first;
        oad_dtype_t dt_second;
    } oad_instr_t;
endpackage : oad_pkg

// >>> hw/oad_operand_dec.sv
`timescale 1ns/100ps
`include "oad_defines.svh"
module oad_operand_dec (
    input oad_pkg::oad_spec_t spec,
    input oad_pkg::oad_dtype_t dt_first,
    input oad_pkg::oad_dtype_t dt_second,
    output oad_pkg::oad_opdec_t dec
);
    import oad_pkg::*;
    oad_dtype_t dt;
    always_comb begin
        dt = spec.dtype;
        if (spec.dtype == DT_FIRST) begin
            dt = dt_first;
        end else if (spec.dtype == DT_SECOND) begin
            dt = dt_second;
        end
        dec = '0;
        dec.eff_dtype = dt;
        case (dt)
            DT_BYTE: dec.size_bytes = 5'h01;
            DT_WORD: dec.size_bytes = 5'h02;
            DT_LONG, DT_FLT_F, DT_FIELD: dec.size_bytes = 5'h04;
            DT_QUAD, DT_FLT_D, DT_FLT_G: dec.size_bytes = 5'h08;
            DT_OCTA, DT_FLT_H: dec.size_bytes = 5'h10;
            default: dec.size_bytes = 5'h04;
        endcase
        case (spec.acc)
            `OAD_ACC_A: dec.addr_out = 1'b1;
            `OAD_ACC_B: dec.branch = 1'b1;
            `OAD_ACC_M: begin
                dec.fetch = 1'b1;
                dec.store = 1'b1;
            end
            `OAD_ACC_R: dec.fetch = 1'b1;
            `OAD_ACC_W: dec.store = 1'b1;
            `OAD_ACC_V: begin
                if (spec.reg_mode) begin
                    dec.reg_pair = 1'b1;
                    dec.reg_hi = spec.reg_num + 4'h1;
                end else begin
                    dec.addr_out = 1'b1;
                end
            end
            default: dec = '0;
        endcase
    end
endmodule : oad_operand_dec

// >>> hw/oad_cond_dec.sv
`timescale 1ns/100ps
`include "oad_defines.svh"
module oad_cond_dec (
    input logic [3:0] cond,
    output logic carry_test,
    output logic carry_level
);
    // Aliased mnemonics collapse into one carry test
    always_comb begin
        carry_test = 1'b0;
        carry_level = 1'b0;
        case (cond)
            `OAD_COND_CARRY_SET, `OAD_COND_UNSIGNED_BELOW: begin
                carry_test = 1'b1;
                carry_level = 1'b1;
            end
            `OAD_COND_CARRY_ZERO, `OAD_COND_UNSIGNED_NOT_BELOW: begin
                carry_test = 1'b1;
                carry_level = 1'b0;
            end
            default: carry_test = 1'b0;
        endcase
    end
endmodule : oad_cond_dec

// >>> hw/oad_decoder.sv
`timescale 1ns/100ps
`include "oad_defines.svh"
// Operation
// - Opcode zero halts in kernel mode, faults in any other mode
// - load_context_op legal only on the interrupt stack
// - save_context_op, write_proc_reg_op, read_proc_reg_op legal only in kernel
// - add_compare_loop_op tests LE on positive addend, GE on negative
// - Address access: no fetch, pass effective address sized by type
// - Data type sets operand size for address calculation
// - Branch access: no memory reference, displacement width from type
// - Modify reads and writes; read access only reads
// - Write access only writes, never reads
// - Field access: address unless register mode, then pair n+1:n
// - Descriptor is name, access letter, data letter
// - unsigned_below_cond and carry set are one carry-set test
// - unsigned_not_below_cond and carry_zero_cond test carry clear
// - unlocked_bit_branch_op modifies bit without interlock
// - locked_bit_branch_op read and write are one interlocked sequence
// - poly_eval_single_op writes registers 0 to 3 implicitly
// - stack_arg_call_op reads count and address, pushes frame longwords
// - Probe instructions check access, transfer no operand data
// - Data letters give sizes and formats, plus first/second type
module oad_decoder (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic VALID,
    input oad_pkg::oad_instr_t INSTR,
    input oad_pkg::oad_spec_t SPEC,
    output oad_pkg::oad_opdec_t OP_ATTR,
    output logic OUT_VALID,
    output logic HALT_REQ,
    output logic PRIV_FAULT,
    output logic WRITE_EN,
    output logic CARRY_TEST,
    output logic CARRY_LEVEL,
    output logic LOOP_TEST_LE,
    output logic BUS_LOCK,
    output logic BIT_MODIFY,
    output logic [15:0] IMPL_REG_WR,
    output logic FRAME_PUSH,
    output logic PROBE_ONLY
);
    import oad_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    oad_opdec_t op_dec_c;
    logic carry_test_c;
    logic carry_level_c;

    oad_operand_dec u_opdec (
        .spec(SPEC),
        .dt_first(INSTR.dt_first),
        .dt_second(INSTR.dt_second),
        .dec(op_dec_c)
    );

    oad_cond_dec u_cond (
        .cond(INSTR.cond),
        .carry_test(carry_test_c),
        .carry_level(carry_level_c)
    );

    ////////////////////////////////////////////////////////////////////////
    oad_opdec_t op_dec_ff;
    oad_opdec_t nxt_op_dec;
    logic valid_ff;
    logic nxt_valid;
    logic halt_ff;
    logic nxt_halt;
    logic fault_ff;
    logic nxt_fault;
    logic wen_ff;
    logic nxt_wen;
    logic ctest_ff;
    logic nxt_ctest;
    logic clevel_ff;
    logic nxt_clevel;
    logic loop_le_ff;
    logic nxt_loop_le;
    logic lock_ff;
    logic nxt_lock;
    logic bitmod_ff;
    logic nxt_bitmod;
    logic [15:0] impl_ff;
    logic [15:0] nxt_impl;
    logic frame_ff;
    logic nxt_frame;
    logic probe_ff;
    logic nxt_probe;
    logic kernel;
    logic illegal;

    ////////////////////////////////////////////////////////////////////////
    // Legality of the opcode in the current mode and stack
    always_comb begin
        kernel = (INSTR.cur_mode == `OAD_MODE_KERNEL);
        illegal = 1'b0;
        case (INSTR.opcode)
            `OAD_OPC_HALT: begin
                illegal = ~kernel;
            end
            `OAD_OPC_LOAD_CTX: begin
                illegal = ~INSTR.on_int_stack;
            end
            `OAD_OPC_SAVE_CTX, `OAD_OPC_WR_PREG, `OAD_OPC_RD_PREG: begin
                illegal = ~kernel;
            end
            default: begin
                illegal = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand and instruction class group
    always_comb begin
        nxt_halt = 1'b0;
        nxt_lock = 1'b0;
        nxt_bitmod = 1'b0;
        nxt_impl = 16'h0000;
        nxt_frame = 1'b0;
        nxt_probe = 1'b0;
        nxt_op_dec = op_dec_c;
        case (INSTR.opcode)
            `OAD_OPC_HALT: begin
                nxt_halt = kernel;
            end
            `OAD_OPC_BIT_SET_SET, `OAD_OPC_BIT_CLR_CLR: begin
                nxt_bitmod = 1'b1;
            end
            `OAD_OPC_LOCK_BIT_SET, `OAD_OPC_LOCK_BIT_CLR: begin
                nxt_bitmod = 1'b1;
                nxt_lock = 1'b1;
            end
            `OAD_OPC_POLY_F: begin
                nxt_impl = `OAD_POLY_REG_MASK;
            end
            `OAD_OPC_CALL_STK: begin
                nxt_frame = 1'b1;
            end
            `OAD_OPC_PROBE_RD, `OAD_OPC_PROBE_WR: begin
                nxt_probe = 1'b1;
                nxt_op_dec.fetch = 1'b0;
                nxt_op_dec.store = 1'b0;
            end
            default: begin
                nxt_halt = 1'b0;
            end
        endcase
        // Suppress every write of an illegal instruction; idle cycles keep their plain decode
        if (VALID && illegal) begin
            nxt_op_dec.store = 1'b0;
            nxt_impl = 16'h0000;
            nxt_frame = 1'b0;
            nxt_lock = 1'b0;
            nxt_bitmod = 1'b0;
        end
        nxt_valid = VALID;
        nxt_halt = VALID & nxt_halt;
        nxt_fault = VALID & illegal;
        nxt_wen = VALID & ~illegal & (nxt_op_dec.store | nxt_op_dec.reg_pair);
    end

    // Hold all state while the enable is low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            op_dec_ff <= '0;
            valid_ff <= 1'b0;
            halt_ff <= 1'b0;
            fault_ff <= 1'b0;
            wen_ff <= 1'b0;
            lock_ff <= 1'b0;
            bitmod_ff <= 1'b0;
            impl_ff <= 16'h0000;
            frame_ff <= 1'b0;
            probe_ff <= 1'b0;
        end else if (CE) begin
            op_dec_ff <= nxt_op_dec;
            valid_ff <= nxt_valid;
            halt_ff <= nxt_halt;
            fault_ff <= nxt_fault;
            wen_ff <= nxt_wen;
            lock_ff <= nxt_lock;
            bitmod_ff <= nxt_bitmod;
            impl_ff <= nxt_impl;
            frame_ff <= nxt_frame;
            probe_ff <= nxt_probe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition and loop direction group, independent of legality
    always_comb begin
        nxt_ctest = carry_test_c;
        nxt_clevel = carry_level_c;
        nxt_loop_le = ~INSTR.addend_neg;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctest_ff <= 1'b0;
            clevel_ff <= 1'b0;
            loop_le_ff <= 1'b0;
        end else if (CE) begin
            ctest_ff <= nxt_ctest;
            clevel_ff <= nxt_clevel;
            loop_le_ff <= nxt_loop_le;
        end
    end

    assign OP_ATTR = op_dec_ff;
    assign OUT_VALID = valid_ff;
    assign HALT_REQ = halt_ff;
    assign PRIV_FAULT = fault_ff;
    assign WRITE_EN = wen_ff;
    assign CARRY_TEST = ctest_ff;
    assign CARRY_LEVEL = clevel_ff;
    assign LOOP_TEST_LE = loop_le_ff;
    assign BUS_LOCK = lock_ff;
    assign BIT_MODIFY = bitmod_ff;
    assign IMPL_REG_WR = impl_ff;
    assign FRAME_PUSH = frame_ff;
    assign PROBE_ONLY = probe_ff;

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    halt_kernel_only_a: assert property (CE && VALID && INSTR.opcode == `OAD_OPC_HALT |=>
        HALT_REQ == $past(INSTR.cur_mode == `OAD_MODE_KERNEL) && PRIV_FAULT != HALT_REQ)
        else $error("halt decode wrong");
    halt_valid_a: assert property (HALT_REQ |-> OUT_VALID && !PRIV_FAULT)
        else $error("halt without legal instruction");
    load_ctx_stack_a: assert property (CE && VALID && INSTR.opcode == `OAD_OPC_LOAD_CTX |=>
        PRIV_FAULT == !$past(INSTR.on_int_stack)) else $error("load context legality wrong");
    kernel_only_ops_a: assert property (CE && VALID && INSTR.opcode == `OAD_OPC_WR_PREG |=>
        PRIV_FAULT == ($past(INSTR.cur_mode) != `OAD_MODE_KERNEL)) else $error("kernel check wrong");
    save_ctx_kernel_a: assert property (CE && VALID && INSTR.opcode == `OAD_OPC_SAVE_CTX |=>
        PRIV_FAULT == ($past(INSTR.cur_mode) != `OAD_MODE_KERNEL))
        else $error("save context legality wrong");
    read_preg_kernel_a: assert property (CE && VALID && INSTR.opcode == `OAD_OPC_RD_PREG |=>
        PRIV_FAULT == ($past(INSTR.cur_mode) != `OAD_MODE_KERNEL))
        else $error("register read legality wrong");
    loop_test_dir_a: assert property (CE |=> LOOP_TEST_LE == !$past(INSTR.addend_neg))
        else $error("loop test direction wrong");
    addr_no_fetch_a: assert property (OP_ATTR.addr_out |-> !OP_ATTR.fetch && !OP_ATTR.store)
        else $error("address operand fetched");
    addr_access_a: assert property (CE && SPEC.acc == `OAD_ACC_A |=> OP_ATTR.addr_out)
        else $error("address operand not passed");
    byte_size_a: assert property (CE && SPEC.acc <= `OAD_ACC_W && SPEC.dtype == DT_BYTE |=>
        OP_ATTR.size_bytes == 5'h01)
        else $error("byte size wrong");
    octa_size_a: assert property (CE && SPEC.acc <= `OAD_ACC_W && SPEC.dtype == DT_OCTA |=>
        OP_ATTR.size_bytes == 5'h10)
        else $error("octaword size wrong");
    branch_no_ref_a: assert property (OP_ATTR.branch |-> !OP_ATTR.fetch && !OP_ATTR.store)
        else $error("branch operand referenced");
    branch_access_a: assert property (CE && SPEC.acc == `OAD_ACC_B |=> OP_ATTR.branch)
        else $error("branch operand not flagged");
    write_no_read_a: assert property (CE && SPEC.acc == `OAD_ACC_W |=> !OP_ATTR.fetch)
        else $error("write operand read");
    modify_both_a: assert property (CE && SPEC.acc == `OAD_ACC_M && !(VALID && illegal) && !nxt_probe |=>
        OP_ATTR.fetch && OP_ATTR.store) else $error("modify operand not read and written");
    read_only_a: assert property (CE && SPEC.acc == `OAD_ACC_R && !nxt_probe |=>
        OP_ATTR.fetch && !OP_ATTR.store)
        else $error("read operand stored");
    field_pair_a: assert property (CE && SPEC.acc == `OAD_ACC_V && SPEC.reg_mode |=>
        OP_ATTR.reg_pair && OP_ATTR.reg_hi == $past(SPEC.reg_num) + 4'h1)
        else $error("field register pair wrong");
    first_type_a: assert property (CE && SPEC.acc <= `OAD_ACC_W && SPEC.dtype == DT_FIRST |=>
        OP_ATTR.eff_dtype == $past(INSTR.dt_first))
        else $error("first data type not taken");
    second_type_a: assert property (CE && SPEC.acc <= `OAD_ACC_W && SPEC.dtype == DT_SECOND |=>
        OP_ATTR.eff_dtype == $past(INSTR.dt_second))
        else $error("second data type not taken");
    carry_alias_a: assert property (CE && (INSTR.cond == `OAD_COND_UNSIGNED_BELOW ||
        INSTR.cond == `OAD_COND_CARRY_SET) |=> CARRY_TEST && CARRY_LEVEL) else $error("carry set alias wrong");
    carry_clear_alias_a: assert property (CE && (INSTR.cond == `OAD_COND_UNSIGNED_NOT_BELOW ||
        INSTR.cond == `OAD_COND_CARRY_ZERO) |=> CARRY_TEST && !CARRY_LEVEL)
        else $error("carry clear alias wrong");
    unlocked_bit_a: assert property (CE && (INSTR.opcode == `OAD_OPC_BIT_SET_SET ||
        INSTR.opcode == `OAD_OPC_BIT_CLR_CLR) |=> BIT_MODIFY && !BUS_LOCK)
        else $error("plain bit branch locked");
    locked_bit_a: assert property (BUS_LOCK |-> BIT_MODIFY)
        else $error("lock without bit modify");
    locked_seq_a: assert property (CE && (INSTR.opcode == `OAD_OPC_LOCK_BIT_SET ||
        INSTR.opcode == `OAD_OPC_LOCK_BIT_CLR) |=> BUS_LOCK && BIT_MODIFY)
        else $error("interlocked bit branch not locked");
    poly_impl_regs_a: assert property (CE && INSTR.opcode == `OAD_OPC_POLY_F |=>
        IMPL_REG_WR == `OAD_POLY_REG_MASK)
        else $error("implied register writes wrong");
    call_frame_a: assert property (CE && INSTR.opcode == `OAD_OPC_CALL_STK |=> FRAME_PUSH)
        else $error("call frame push missing");
    probe_no_data_a: assert property (PROBE_ONLY |-> !OP_ATTR.fetch && !OP_ATTR.store)
        else $error("probe transfers operand data");
    fault_no_write_a: assert property (PRIV_FAULT |->
        !WRITE_EN && !OP_ATTR.store && IMPL_REG_WR == 16'h0000)
        else $error("write not suppressed on fault");
    write_legal_a: assert property (WRITE_EN |-> OUT_VALID && !PRIV_FAULT)
        else $error("write granted to faulted instruction");
    out_valid_follow_a: assert property (CE |=> OUT_VALID == $past(VALID))
        else $error("output valid does not follow input");
    ce_freeze_hold_a: assert property (!CE |=> $stable(OP_ATTR) && $stable(OUT_VALID) &&
        $stable(PRIV_FAULT) && $stable(WRITE_EN) && $stable(LOOP_TEST_LE))
        else $error("state moved while enable low");

    halt_cov_c: cover property (HALT_REQ);
    fault_cov_c: cover property (PRIV_FAULT);
    lock_cov_c: cover property (BUS_LOCK);
    pair_cov_c: cover property (OP_ATTR.reg_pair);
    probe_cov_c: cover property (PROBE_ONLY);
endmodule : oad_decoder

// >>> verif/oad_exec_model.sv
`timescale 1ns/100ps
module oad_exec_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic out_valid,
    input wire logic write_en,
    output logic [7:0] store_cnt
);
    logic [7:0] nxt_store_cnt;
    // Commits every granted store; a faulted instruction must add none
    always_comb begin
        nxt_store_cnt = store_cnt + {7'h00, out_valid & write_en};
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_cnt <= 8'h00;
        end else begin
            store_cnt <= nxt_store_cnt;
        end
    end
endmodule : oad_exec_model

// >>> verif/oad_decoder_tb.sv
`timescale 1ns/100ps
`include "oad_defines.svh"
module oad_decoder_tb;
    import oad_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic valid = 1'b0;
    oad_instr_t instr = '0;
    oad_spec_t spec = '0;
    oad_opdec_t dec;
    logic ov, halt, fault, wen, ct, cl, le, lock, bmod, push, probe;
    logic [15:0] impl;
    logic [7:0] cnt;
    int mismatches = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    oad_decoder i_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .VALID(valid), .INSTR(instr), .SPEC(spec),
        .OP_ATTR(dec), .OUT_VALID(ov), .HALT_REQ(halt), .PRIV_FAULT(fault), .WRITE_EN(wen),
        .CARRY_TEST(ct), .CARRY_LEVEL(cl), .LOOP_TEST_LE(le), .BUS_LOCK(lock), .BIT_MODIFY(bmod),
        .IMPL_REG_WR(impl), .FRAME_PUSH(push), .PROBE_ONLY(probe));
    oad_exec_model i_exec (.clk(clk), .rst_n(rst_n), .out_valid(ov), .write_en(wen), .store_cnt(cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Inputs change at the falling edge; result of one edge later is read here
    task automatic issue(logic [7:0] op, logic [1:0] md, logic stk, oad_spec_t sp);
        instr.opcode = op;
        instr.cur_mode = md;
        instr.on_int_stack = stk;
        spec = sp;
        valid = 1'b1;
        @(negedge clk);
    endtask : issue
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_access();
        int sz [12] = '{1, 2, 4, 8, 16, 4, 8, 8, 16, 4, 8, 2};
        int ed;
        instr.dt_first = DT_QUAD;
        instr.dt_second = DT_WORD;
        for (int a = 0; a < 6; a++) begin
            for (int d = 0; d < 12; d++) begin
                issue(8'h01, 2'h0, 1'b0, '{a[2:0], oad_dtype_t'(d), 1'b0, 4'h0});
                ed = (d == 10) ? 3 : (d == 11) ? 1 : d;
                check("fetch", dec.fetch, 6'b001100 >> a & 1);
                check("store", dec.store, 6'b100100 >> a & 1);
                check("addr", dec.addr_out, 6'b010001 >> a & 1);
                check("branch", dec.branch, a == 1);
                check("size", dec.size_bytes, sz[d]);
                check("dtype", dec.eff_dtype, ed);
            end
        end
    endtask : t_access
    task automatic t_field();
        issue(8'h01, 2'h0, 1'b0, '{`OAD_ACC_V, DT_LONG, 1'b1, 4'h3});
        check("pair", dec.reg_pair, 1);
        check("hi", dec.reg_hi, 4);
        issue(8'h01, 2'h0, 1'b0, '{`OAD_ACC_V, DT_LONG, 1'b1, 4'hf});
        check("hi wrap", dec.reg_hi, 0);
    endtask : t_field
    // Legal and illegal privileged decodes back to back; stores counted downstream
    task automatic t_priv();
        logic [7:0] op [10] = '{8'h06, 8'h06, 8'h07, 8'h07, 8'hda, 8'hda, 8'hdb, 8'hdb, 8'h00, 8'h00};
        logic [1:0] md [10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0, 2'h2, 2'h0, 2'h1};
        logic bad [10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        logic [7:0] c0;
        // Let the last store of the previous scenario retire before counting
        valid = 1'b0;
        @(negedge clk);
        c0 = cnt;
        for (int i = 0; i < 10; i++) begin
            issue(op[i], md[i], i < 2 ? !bad[i] : 1'b0, '{`OAD_ACC_W, DT_LONG, 1'b0, 4'h0});
            check("fault", fault, bad[i]);
            check("wen", wen, !bad[i]);
            check("halt", halt, op[i] == 0 && !bad[i]);
        end
        valid = 1'b0;
        @(negedge clk);
        check("ov idle", ov, 0);
        check("stores", cnt, c0 + 5);
    endtask : t_priv
    task automatic t_cond_loop();
        for (int c = 6; c < 10; c++) begin
            instr.cond = c[3:0];
            issue(8'h01, 2'h0, 1'b0, spec);
            check("ctest", ct, 1);
            check("clevel", cl, c < 8);
        end
        instr.addend_neg = 1'b0;
        issue(8'h01, 2'h0, 1'b0, spec);
        check("le", le, 1);
        // Frozen clock enable must hold the last answer
        ce = 1'b0;
        instr.addend_neg = 1'b1;
        issue(8'h01, 2'h0, 1'b0, spec);
        check("frozen", le, 1);
        ce = 1'b1;
        issue(8'h01, 2'h0, 1'b0, spec);
        check("ge", le, 0);
    endtask : t_cond_loop
    task automatic t_ops();
        logic [7:0] bb [4] = '{8'he2, 8'he5, 8'he6, 8'he7};
        for (int i = 0; i < 4; i++) begin
            issue(bb[i], 2'h0, 1'b0, spec);
            check("bmod", bmod, 1);
            check("lock", lock, i > 1);
        end
        issue(`OAD_OPC_POLY_F, 2'h0, 1'b0, spec);
        check("impl", impl, 16'h000f);
        issue(`OAD_OPC_CALL_STK, 2'h0, 1'b0, spec);
        check("push", push, 1);
        check("impl off", impl, 0);
        for (int i = 0; i < 2; i++) begin
            issue(8'h0c + i[7:0], 2'h0, 1'b0, '{`OAD_ACC_M, DT_LONG, 1'b0, 4'h0});
            check("probe", probe, 1);
            check("probe data", {dec.fetch, dec.store}, 0);
        end
    endtask : t_ops
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        check("reset dec", dec, 0);
        check("reset ov", ov, 0);
        rst_n = 1'b1;
        t_access();
        t_field();
        t_priv();
        t_cond_loop();
        t_ops();
        print_verdict();
    end
endmodule : oad_decoder_tb
